// ===== tcs_clock_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Phase-align reset ignored while source select and rate select are both low.
// - Characters may be dropped on all channels while buffers are aligning.
// - Source select low: all four input registers load on reference rising edge.
// - Source select middle: each channel loads data and control on own clock.
// - Source select high: channel A clock loads every channel's input register.
// - Character clock out equals bit clock over ten: reference or twice it.
// - Character clock out has no fixed phase to reference or receive clocks.
// - Rate high makes bit clock twenty times reference; low makes it ten times.
// - Reference-driven receive clocks are half rate when rate high, else full.
// - Special-character select sampled on channel A or reference edge per source.
// - Channel phase adjusts while reset is low and freezes once it is high.
module tcs_clock_ctrl
   import tcs_pkg::*;
#(
   parameter int CNT_W = tcs_pkg::TCS_CNT_W
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_reference_clock_in,
   input wire logic [tcs_pkg::TCS_CHANNELS-1:0] i_per_channel_input_clock,
   input wire logic [31:0] i_tx_data_byte,
   input wire logic [7:0] i_tx_control_bits,
   input wire logic i_special_char_select,
   input wire logic [1:0] i_tx_clock_source_select,
   input wire logic i_tx_pll_rate_select,
   input wire logic i_tx_phase_align_reset_n,
   input wire logic i_rx_clock_source_select,
   output logic o_tx_char_clock_out,
   output logic o_rx_output_clock_a,
   output logic [31:0] o_tx_data_byte,
   output logic [7:0] o_tx_control_bits,
   output logic [tcs_pkg::TCS_CHANNELS-1:0] o_tx_char_valid,
   output logic o_special_char_select,
   output logic o_align_active,
   output logic [31:0] o_phase_offset
);
   import tcs_pkg::*;

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [TCS_CLK_W-1:0] clk_lvl;
   logic [TCS_CLK_W-1:0] clk_rise;
   logic [TCS_PIN_W-1:0] pin_lvl;

   tcs_sync #(.W(TCS_CLK_W)) u_clk_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_reference_clock_in, i_per_channel_input_clock}),
      .o_level(clk_lvl),
      .o_rise(clk_rise)
   );

   tcs_sync #(.W(TCS_PIN_W)) u_pin_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async({i_rx_clock_source_select, i_tx_phase_align_reset_n, i_tx_pll_rate_select,
                i_tx_clock_source_select, i_special_char_select, i_tx_control_bits,
                i_tx_data_byte}),
      .o_level(pin_lvl),
      .o_rise()
   );

   // Unused code 2'b10 is taken as the high level, the safest shared-clock mode.
   function automatic tcs_src_t tcs_decode_src(input logic [1:0] code);
      unique case (code)
         2'b00: tcs_decode_src = TCS_SRC_REF;
         2'b01: tcs_decode_src = TCS_SRC_CHAN;
         default: tcs_decode_src = TCS_SRC_CHA;
      endcase
   endfunction : tcs_decode_src

   tcs_src_t src;
   logic rate;
   logic rst_n_s;
   logic rx_sel;
   logic ref_lvl;
   logic ref_rise;
   logic cha_rise;
   logic ignore_rst;
   assign src = tcs_decode_src(pin_lvl[TCS_POS_SRC +: 2]);
   assign rate = pin_lvl[TCS_POS_RATE];
   assign rst_n_s = pin_lvl[TCS_POS_RST_N];
   assign rx_sel = pin_lvl[TCS_POS_RXSEL];
   assign ref_lvl = clk_lvl[TCS_REF_IDX];
   assign ref_rise = clk_rise[TCS_REF_IDX];
   assign cha_rise = clk_rise[0];
   assign ignore_rst = (src == TCS_SRC_REF) && !rate;

   // ****************************************************************
   // Phase-align reset sequencing
   // ****************************************************************
   tcs_align_t align_reg;
   tcs_align_t align_next;

   // One low reference edge starts alignment; channel A needs two in a row.
   always_comb
   begin
      align_next = align_reg;
      unique case (align_reg)
         TCS_AL_IDLE:
            if (!ignore_rst && !rst_n_s && ref_rise)
               align_next = TCS_AL_ACTIVE;
            else if (!ignore_rst && !rst_n_s && cha_rise)
               align_next = TCS_AL_ARM;
         TCS_AL_ARM:
            if (ignore_rst || rst_n_s)
               align_next = TCS_AL_IDLE;
            else if (ref_rise || cha_rise)
               align_next = TCS_AL_ACTIVE;
         TCS_AL_ACTIVE:
            if (ignore_rst || rst_n_s)
               align_next = TCS_AL_IDLE;
         default:
            align_next = TCS_AL_IDLE;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         align_reg <= TCS_AL_IDLE;
      else
         align_reg <= align_next;
   end

   // ****************************************************************
   // Input registers and phase tracking per channel
   // ****************************************************************
   logic [TCS_CHANNELS-1:0] cap;
   logic [TCS_CHANNELS-1:0] valid_reg;
   logic [TCS_CHANNELS-1:0] valid_next;
   logic [31:0] data_reg;
   logic [31:0] data_next;
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [31:0] phase_reg;
   logic [31:0] phase_next;
   logic [CNT_W-1:0] since_rise_reg;
   logic [CNT_W-1:0] since_rise_next;
   logic aligning;
   assign aligning = (align_reg == TCS_AL_ACTIVE);

   genvar g;
   generate
      for (g = 0; g < TCS_CHANNELS; g++)
      begin : g_chan
         // Pick the load strobe for this channel from the source select.
         always_comb
         begin
            cap[g] = 1'b0;
            unique case (src)
               TCS_SRC_REF: cap[g] = ref_rise;
               TCS_SRC_CHAN: cap[g] = clk_rise[g];
               TCS_SRC_CHA: cap[g] = cha_rise;
            endcase
         end

         // Loads are dropped while aligning, so characters may be lost then.
         always_comb
         begin
            valid_next[g] = cap[g] && !aligning;
            data_next[g*TCS_BYTE_W +: TCS_BYTE_W] = valid_next[g] ?
               pin_lvl[TCS_POS_DATA + g*TCS_BYTE_W +: TCS_BYTE_W] :
               data_reg[g*TCS_BYTE_W +: TCS_BYTE_W];
            ctrl_next[g*TCS_CTRL_W +: TCS_CTRL_W] = valid_next[g] ?
               pin_lvl[TCS_POS_CTRL + g*TCS_CTRL_W +: TCS_CTRL_W] :
               ctrl_reg[g*TCS_CTRL_W +: TCS_CTRL_W];
            // The offset to the reference edge is only updated while aligning.
            phase_next[g*8 +: 8] = (aligning && clk_rise[g]) ?
               8'(since_rise_reg) : phase_reg[g*8 +: 8];
         end
      end
   endgenerate

   // ****************************************************************
   // Special-character select sampling
   // ****************************************************************
   logic sc_reg;
   logic sc_next;
   logic sc_strobe;

   // The host pairs this bit with channel A's control bits, so it shares their edge.
   always_comb
   begin
      sc_strobe = (src == TCS_SRC_REF) ? ref_rise : cha_rise;
      sc_next = sc_strobe ? pin_lvl[TCS_POS_SC] : sc_reg;
   end

   // ****************************************************************
   // Character and receive clock synthesis
   // ****************************************************************
   logic ref_prev_reg;
   logic [CNT_W-1:0] since_chg_reg;
   logic [CNT_W-1:0] since_chg_next;
   logic [CNT_W-1:0] half_reg;
   logic [CNT_W-1:0] half_next;
   logic char_reg;
   logic char_next;
   logic rx_reg;
   logic rx_next;
   logic ref_chg;
   assign ref_chg = ref_lvl ^ ref_prev_reg;

   // Twice the reference is made by a second toggle at mid half-period; the
   // half-period is measured, so a jittery reference gives an uneven duty.
   always_comb
   begin
      since_rise_next = ref_rise ? TCS_CNT_RST :
         ((&since_rise_reg) ? since_rise_reg : since_rise_reg + 1'b1);
      since_chg_next = ref_chg ? TCS_CNT_RST :
         ((&since_chg_reg) ? since_chg_reg : since_chg_reg + 1'b1);
      half_next = (ref_chg && since_chg_reg >= TCS_HALF_RST) ? since_chg_reg : half_reg;
      if (!rate)
         char_next = ref_lvl;
      else if (ref_chg || (since_chg_reg == (half_reg >> 1)))
         char_next = !char_reg;
      else
         char_next = char_reg;
      if (rx_sel)
         rx_next = 1'b0;
      else if (rate)
         rx_next = ref_rise ? !rx_reg : rx_reg;
      else
         rx_next = ref_lvl;
   end

   // ****************************************************************
   // State registers
   // ****************************************************************
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         valid_reg <= '0;
         data_reg <= '0;
         ctrl_reg <= '0;
         phase_reg <= '0;
         since_rise_reg <= TCS_CNT_RST;
         since_chg_reg <= TCS_CNT_RST;
         half_reg <= TCS_HALF_RST;
         ref_prev_reg <= 1'b0;
         char_reg <= 1'b0;
         rx_reg <= 1'b0;
         sc_reg <= 1'b0;
      end
      else
      begin
         valid_reg <= valid_next;
         data_reg <= data_next;
         ctrl_reg <= ctrl_next;
         phase_reg <= phase_next;
         since_rise_reg <= since_rise_next;
         since_chg_reg <= since_chg_next;
         half_reg <= half_next;
         ref_prev_reg <= ref_lvl;
         char_reg <= char_next;
         rx_reg <= rx_next;
         sc_reg <= sc_next;
      end
   end

   assign o_tx_char_clock_out = char_reg;
   assign o_rx_output_clock_a = rx_reg;
   assign o_tx_data_byte = data_reg;
   assign o_tx_control_bits = ctrl_reg;
   assign o_tx_char_valid = valid_reg;
   assign o_special_char_select = sc_reg;
   assign o_align_active = align_reg[1];
   assign o_phase_offset = phase_reg;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_ignore_blocks_align: assert property (ignore_rst |=> align_reg == TCS_AL_IDLE)
      else $error("Alignment entered while reset is ignored.");
   a_two_edge_start: assert property (align_reg == TCS_AL_ARM && cha_rise && !rst_n_s
      && !ignore_rst |=> o_align_active)
      else $error("Second low channel A edge did not start alignment.");
   a_drop_while_align: assert property (aligning |=> valid_reg == '0)
      else $error("Character loaded during alignment.");
   a_ref_loads_all: assert property (src == TCS_SRC_REF && ref_rise && !aligning
      |=> valid_reg == 4'hf)
      else $error("Reference edge did not load all channels.");
   a_own_clock_load: assert property (src == TCS_SRC_CHAN && clk_rise[1] && !aligning
      |=> valid_reg[1] && ctrl_reg[3:2] == $past(pin_lvl[TCS_POS_CTRL+2 +: 2]))
      else $error("Channel clock did not load its own register.");
   a_cha_loads_all: assert property (src == TCS_SRC_CHA && cha_rise && !aligning
      |=> valid_reg == 4'hf)
      else $error("Channel A edge did not load all channels.");
   a_char_full_rate: assert property (!rate |=> char_reg == $past(ref_lvl))
      else $error("Character clock does not follow reference at low rate.");
   a_rx_half_rate: assert property (!rx_sel && rate && ref_rise |=> rx_reg != $past(rx_reg))
      else $error("Receive clock did not toggle on reference edge.");
   a_sc_sample: assert property (sc_strobe |=> sc_reg == $past(pin_lvl[TCS_POS_SC]))
      else $error("Special-character select not sampled.");
   a_phase_frozen: assert property (!aligning |=> $stable(phase_reg))
      else $error("Phase offset moved outside alignment.");
endmodule : tcs_clock_ctrl
`default_nettype wire

// ===== tcs_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants and types of the transmit clock control.
// ****************************************************************
package tcs_pkg;
   localparam int TCS_CHANNELS = 4;
   localparam int TCS_BYTE_W = 8;
   localparam int TCS_CTRL_W = 2;
   localparam int TCS_CNT_W = 8;
   localparam int TCS_SYNC_STAGES = 2;
   // Field positions inside the synchronised pin bundle.
   localparam int TCS_POS_DATA = 0;
   localparam int TCS_POS_CTRL = 32;
   localparam int TCS_POS_SC = 40;
   localparam int TCS_POS_SRC = 41;
   localparam int TCS_POS_RATE = 43;
   localparam int TCS_POS_RST_N = 44;
   localparam int TCS_POS_RXSEL = 45;
   localparam int TCS_PIN_W = 46;
   // Index of the reference clock in the clock bundle; channels use 0..3.
   localparam int TCS_REF_IDX = 4;
   localparam int TCS_CLK_W = 5;
   // Reset values.
   localparam logic [TCS_CNT_W-1:0] TCS_CNT_RST = 8'h00;
   localparam logic [TCS_CNT_W-1:0] TCS_HALF_RST = 8'h02;
   // Three-level source select, coded as two pin bits.
   typedef enum logic [1:0] {
      TCS_SRC_REF = 2'b00,
      TCS_SRC_CHAN = 2'b01,
      TCS_SRC_CHA = 2'b11
   } tcs_src_t;
   typedef enum logic [1:0] {
      TCS_AL_IDLE = 2'b00,
      TCS_AL_ARM = 2'b01,
      TCS_AL_ACTIVE = 2'b11
   } tcs_align_t;
endpackage : tcs_pkg
`default_nettype wire

// ===== tcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-stage synchroniser with rise detection on the settled stage.
// ****************************************************************
module tcs_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_level,
   output logic [W-1:0] o_rise
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;
   logic [W-1:0] prev_reg;
   logic [W-1:0] prev_next;

   // Only the second stage feeds logic; the first stage may be metastable.
   always_comb
   begin
      meta_next = i_async;
      sync_next = meta_reg;
      prev_next = sync_reg;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
         prev_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~prev_reg;
endmodule : tcs_sync
`default_nettype wire

// ===== tcs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host-side clock source: reference clock and four channel clocks.
// ****************************************************************
module tcs_host_model #(
   parameter int HALF = 8,
   parameter int SKEW = 2
) (
   input wire logic i_clk,
   input wire logic i_run,
   input wire logic i_ref_off,
   output logic o_ref,
   output logic [3:0] o_chan
);
   logic [4:0] ph_reg;
   logic on_reg;

   // The phase count moves on the falling edge so that the pins settle before sampling.
   always_ff @(negedge i_clk)
   begin
      on_reg <= i_run;
      ph_reg <= (i_run && on_reg) ? 5'((ph_reg + 5'h01) % (2 * HALF)) : 5'h00;
   end

   // Every clock shares one period, so the channel clocks stay coherent.
   // Outside a burst all clocks stand still low, as a stopped host would leave them.
   always_comb
   begin
      // A held reference lets the channel A clock alone start alignment.
      o_ref = on_reg && !i_ref_off && (ph_reg < 5'(HALF));
      for (int n = 0; n < 4; n++)
      begin
         o_chan[n] = on_reg && (5'((ph_reg + 2 * HALF - SKEW * (n + 1)) % (2 * HALF)) < 5'(HALF));
      end
   end
endmodule : tcs_host_model
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import tcs_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic run = 1'b0;
   logic ref_off = 1'b0;
   logic ref_clk;
   logic [3:0] chan_clk;
   logic [31:0] data = 32'h0;
   logic [7:0] ctrl = 8'h00;
   logic sc = 1'b0;
   logic [1:0] src = 2'b00;
   logic rate = 1'b0;
   logic rst_n = 1'b1;
   logic rx_sel = 1'b0;
   logic o_char, o_rx, o_sc, o_align;
   logic [31:0] o_data, o_phase;
   logic [7:0] o_ctrl;
   logic [3:0] o_valid;
   logic char_q = 1'b0;
   logic rx_q = 1'b0;
   logic cnt_en = 1'b0;
   int cyc, ccnt, rcnt, lat;
   int vcnt[4];
   int first[4];
   int fail_count = 0;
   int checked = 0;

   always #2 i_clk = ~i_clk;

   tcs_host_model u_host (.i_clk(i_clk), .i_run(run), .i_ref_off(ref_off), .o_ref(ref_clk),
      .o_chan(chan_clk));

   tcs_clock_ctrl u_dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_reference_clock_in(ref_clk),
      .i_per_channel_input_clock(chan_clk), .i_tx_data_byte(data), .i_tx_control_bits(ctrl),
      .i_special_char_select(sc), .i_tx_clock_source_select(src),
      .i_tx_pll_rate_select(rate), .i_tx_phase_align_reset_n(rst_n),
      .i_rx_clock_source_select(rx_sel), .o_tx_char_clock_out(o_char),
      .o_rx_output_clock_a(o_rx), .o_tx_data_byte(o_data), .o_tx_control_bits(o_ctrl),
      .o_tx_char_valid(o_valid), .o_special_char_select(o_sc),
      .o_align_active(o_align), .o_phase_offset(o_phase));

   // ****************************************************************
   // Monitor: load pulses, first load cycle and output clock rises.
   // ****************************************************************
   always @(posedge i_clk)
   begin
      cyc = cyc + 1;
      for (int n = 0; n < 4; n++)
      begin
         if (o_valid[n] === 1'b1)
         begin
            vcnt[n]++;
            if (first[n] < 0) first[n] = cyc;
         end
      end
      if (cnt_en && o_char === 1'b1 && char_q === 1'b0) ccnt++;
      if (cnt_en && o_rx === 1'b1 && rx_q === 1'b0) rcnt++;
      char_q = o_char;
      rx_q = o_rx;
   end

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_val

   task automatic chk_cnt(input string name, input int exp, input int got);
      checked++;
      if (got != exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %0d seen %0d", name, exp, got);
      end
   endtask : chk_cnt

   // Twelve reference periods; output clocks are counted over eight whole periods.
   task automatic run_clocks();
      repeat (4) @(negedge i_clk);
      cyc = 0;
      ccnt = 0;
      rcnt = 0;
      for (int n = 0; n < 4; n++)
      begin
         vcnt[n] = 0;
         first[n] = -1;
      end
      run <= 1'b1;
      repeat (65) @(negedge i_clk);
      cnt_en = 1'b1;
      repeat (127) @(negedge i_clk);
      run <= 1'b0;
      @(negedge i_clk);
      cnt_en = 1'b0;
      repeat (8) @(negedge i_clk);
   endtask : run_clocks

   task automatic chk_loads(input int exp);
      for (int n = 0; n < 4; n++) chk_cnt("load count", exp, vcnt[n]);
   endtask : chk_loads

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_src_low();
      src = 2'b00;
      rate = 1'b1;
      data = 32'ha1b2c3d4;
      ctrl = 8'hc6;
      sc = 1'b1;
      run_clocks();
      chk_loads(12);
      for (int n = 1; n < 4; n++) chk_cnt("same edge", first[0], first[n]);
      lat = first[0];
      chk_val("data", 32'ha1b2c3d4, o_data);
      chk_val("ctrl", 32'h000000c6, {24'h0, o_ctrl});
      chk_val("special", 32'h1, {31'h0, o_sc});
      chk_cnt("char clock double", 16, ccnt);
      chk_cnt("rx clock half", 4, rcnt);
   endtask : t_src_low

   task automatic t_src_mid();
      src = 2'b01;
      rate = 1'b0;
      data = 32'h5e6f7081;
      ctrl = 8'h39;
      run_clocks();
      chk_loads(12);
      for (int n = 0; n < 4; n++) chk_cnt("own edge", lat + 2 * (n + 1), first[n]);
      chk_val("data", 32'h5e6f7081, o_data);
      chk_val("ctrl", 32'h00000039, {24'h0, o_ctrl});
      chk_cnt("char clock single", 8, ccnt);
      chk_cnt("rx clock full", 8, rcnt);
   endtask : t_src_mid

   task automatic t_src_high();
      src = 2'b11;
      rate = 1'b1;
      rx_sel = 1'b1;
      sc = 1'b0;
      data = 32'h0f1e2d3c;
      run_clocks();
      for (int n = 0; n < 4; n++) chk_cnt("channel A edge", lat + 2, first[n]);
      chk_val("data", 32'h0f1e2d3c, o_data);
      chk_val("special", 32'h0, {31'h0, o_sc});
      chk_cnt("rx clock off", 0, rcnt);
      rx_sel = 1'b0;
   endtask : t_src_high

   task automatic t_ignore();
      src = 2'b00;
      rate = 1'b0;
      rst_n = 1'b0;
      data = 32'h96877869;
      run_clocks();
      chk_val("align ignored", 32'h0, {31'h0, o_align});
      chk_loads(12);
      chk_val("data", 32'h96877869, o_data);
   endtask : t_ignore

   task automatic t_align();
      src = 2'b01;
      data = 32'h13579bdf;
      run_clocks();
      chk_val("align active", 32'h1, {31'h0, o_align});
      chk_loads(0);
      chk_val("data held", 32'h96877869, o_data);
      // The offset counter restarts one cycle after the reference edge is seen.
      chk_val("phase offset", 32'h07050301, o_phase);
      rst_n = 1'b1;
      repeat (8) @(negedge i_clk);
      chk_val("align released", 32'h0, {31'h0, o_align});
      run_clocks();
      chk_loads(12);
      chk_val("data", 32'h13579bdf, o_data);
   endtask : t_align

   // Reference held still: only two low channel A edges can start alignment.
   // The second edge still loads, since alignment begins one cycle after it.
   task automatic t_two_edge();
      src = 2'b10;
      rate = 1'b1;
      ref_off = 1'b1;
      rst_n = 1'b0;
      data = 32'h2468ace0;
      run_clocks();
      chk_val("align two edges", 32'h1, {31'h0, o_align});
      chk_loads(2);
      for (int n = 0; n < 4; n++) chk_cnt("shared edge", lat + 2, first[n]);
      chk_val("data", 32'h2468ace0, o_data);
      rst_n = 1'b1;
      ref_off = 1'b0;
      repeat (8) @(negedge i_clk);
      chk_val("align released", 32'h0, {31'h0, o_align});
   endtask : t_two_edge

   // ****************************************************************
   // Verdict, watchdog and main sequence.
   // ****************************************************************
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // The full run needs under 2000 cycles, so this leaves ample slack.
   initial
   begin
      repeat (20000) @(posedge i_clk);
      fail_count++;
      stop_test();
   end

   initial
   begin
      repeat (8) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (4) @(negedge i_clk);
      t_src_low();
      t_src_mid();
      t_src_high();
      t_ignore();
      t_align();
      t_two_edge();
      stop_test();
   end
endmodule : tb
`default_nettype wire
